// ### hw/sync_mode_detector_params.svh
// Purpose: Offsets, field positions, reset values and counts of the sync mode detector.
// Assumes: Included by the detector module after its timescale line.
// Notes: Register offsets are word indexes on the plain register port.
`ifndef SYNC_MODE_DETECTOR_PARAMS_SVH
`define SYNC_MODE_DETECTOR_PARAMS_SVH

`define ADDR_CTRL 4'h0
`define ADDR_FREE_RUN 4'h1
`define ADDR_LINE_STATUS 4'h2
`define ADDR_FRAME_STATUS 4'h3

`define CTRL_MODE_LSB 0
`define CTRL_WIDTH_LSB 2
`define CTRL_RESET 16'h0020
`define FREE_RUN_RESET 12'h3E8
`define STATUS_POL_BIT 12
`define STATUS_ABSENT_BIT 13

`define UPPER_THRESHOLD 12'hFF0
`define LOWER_THRESHOLD 12'hFC0
`define PERIOD_TOLERANCE 12'h002
`define SUB_MARGIN 12'h008
`define FRAME_DIVIDE 7'h4C
`define RISE_LIMIT 4'hF
`define FALL_LIMIT 2'h3
`define FRAME_PERSIST 3'h4
`define POL_NEG_TO_POS 6'h26
`define POL_POS_TO_NEG 6'h3C

`endif

// ### hw/sync_mode_detector_pkg.sv
// Purpose: Types shared by the sync mode detector and its users.
// Assumes: Nothing beyond the parameter header.
// Notes: The output mode encoding follows the two mode select bits.
package sync_mode_detector_pkg;

	typedef logic [3:0] reg_addr_t;
	typedef logic [15:0] reg_data_t;
	typedef logic [11:0] period_t;

	typedef enum logic [1:0] {
		MODE_FREE_RUN = 2'h0,
		MODE_COPY_SUB = 2'h1,
		MODE_FIXED_SUB = 2'h2,
		MODE_COPY_ONLY = 2'h3
	} line_mode_t;

endpackage

// ### hw/sync_mode_detector.sv
// Purpose: Line and frame sync mode detection with a line sync output generator.
// Assumes: clk is the line base clock; sync inputs are raw pins of either polarity, detected here.
// Notes: Register port answers a read in the cycle after the strobe.
// Behaviour
// (R1) Line counter clears on fourth pulse or FF0 limit
// (R2) Line period register loads only when enabled
// (R3) Compare every four lines, then restart counter
// (R4) Faster line needs fifteen confirmations
// (R5) Count of 4080 means static line input
// (R6) Slower non-static line needs three confirmations
// (R7) Entering static raises change immediately
// (R8) Absent flag sets at upper threshold
// (R9) Absent flag clears below lower threshold
// (R10) Negative to positive flips after 38 lines
// (R11) Positive to negative flips after 60 lines
// (R12) Polarity flag: positive 0, negative 1
// (R13) Stable period counts filters down, enable low
// (R14) Frame path measures one whole frame
// (R15) Frame clock is line clock over 76
// (R16) Frame polarity sampled at quarter frame
// (R17) Frame change reported after over three frames
// (R18) Output sync takes one of four forms
// (R19) Mode bits select output form
// (R20) Substitution counter reloads on every sync, except in free run
// (R21) Missing sync gives reload, and a substitute pulse in all modes but copy only
// (R22) Free run loads programmed period, ignores syncs
// (R23) All change events merge into one pulse
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`include "sync_mode_detector_params.svh"

module sync_mode_detector (
	input wire logic clk,
	input wire logic rstn,
	input wire logic lineSyncIn,
	input wire logic frameSyncIn,
	input wire sync_mode_detector_pkg::reg_addr_t addr,
	input wire sync_mode_detector_pkg::reg_data_t wdata,
	input wire logic wr,
	input wire logic rd,
	output sync_mode_detector_pkg::reg_data_t rdata,
	output logic lineSyncOutput,
	output logic substituteLinePulse,
	output logic lineUpdateEnable,
	output logic frameUpdateEnable,
	output logic frameBaseClock,
	output logic modeChange
);
	import sync_mode_detector_pkg::*;

	// Returns {faster, slower} of a new period against the locked one.
	function automatic logic [1:0] periodCompare(input period_t measured, input period_t locked);
		logic faster;
		logic slower;
		faster = ({1'b0, measured} + {1'b0, `PERIOD_TOLERANCE}) < {1'b0, locked};
		slower = {1'b0, measured} > ({1'b0, locked} + {1'b0, `PERIOD_TOLERANCE});
		return {faster, slower};
	endfunction

	// Absent flag with hysteresis between the two thresholds.
	function automatic logic nextAbsent(input period_t captured, input logic current);
		logic result;
		result = current;
		if (captured >= `UPPER_THRESHOLD) begin
			result = 1'b1; // see (R8)
		end else if (captured < `LOWER_THRESHOLD) begin
			result = 1'b0; // see (R9)
		end
		return result;
	endfunction

	// Input synchronisers: three stages, a change counts once stages two and three agree.
	logic [2:0] lineShift_reg, lineShift_next;
	logic [2:0] frameShift_reg, frameShift_next;
	logic lineLevel_reg, lineLevel_next;
	logic frameLevel_reg, frameLevel_next;
	logic lineRise;
	logic frameRise;

	always_comb begin
		lineShift_next = {lineShift_reg[1:0], lineSyncIn};
		frameShift_next = {frameShift_reg[1:0], frameSyncIn};
		lineLevel_next = lineLevel_reg;
		frameLevel_next = frameLevel_reg;
		if (lineShift_reg[1] == lineShift_reg[2]) begin
			lineLevel_next = lineShift_reg[2];
		end
		if (frameShift_reg[1] == frameShift_reg[2]) begin
			frameLevel_next = frameShift_reg[2];
		end
		lineRise = lineLevel_next & ~lineLevel_reg;
		frameRise = frameLevel_next & ~frameLevel_reg;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lineShift_reg <= 3'h0;
			frameShift_reg <= 3'h0;
			lineLevel_reg <= 1'b0;
			frameLevel_reg <= 1'b0;
		end else begin
			lineShift_reg <= lineShift_next;
			frameShift_reg <= frameShift_next;
			lineLevel_reg <= lineLevel_next;
			frameLevel_reg <= frameLevel_next;
		end
	end

	// Register file.
	reg_data_t ctrl_reg, ctrl_next;
	period_t freeRun_reg, freeRun_next;
	reg_data_t rdata_reg, rdata_next;
	period_t linePeriod_reg, framePeriod_reg;
	logic lineAbsent_reg, linePol_reg, frameAbsent_reg, framePol_reg;
	line_mode_t lineMode;
	logic [4:0] pulseWidth;

	always_comb begin
		ctrl_next = ctrl_reg;
		freeRun_next = freeRun_reg;
		rdata_next = 16'h0000;
		if (wr && addr == `ADDR_CTRL) begin
			ctrl_next = {9'h000, wdata[6:0]};
		end
		if (wr && addr == `ADDR_FREE_RUN) begin
			freeRun_next = wdata[11:0];
		end
		if (rd) begin
			case (addr)
				`ADDR_CTRL: begin
					rdata_next = ctrl_reg;
				end
				`ADDR_FREE_RUN: begin
					rdata_next = {4'h0, freeRun_reg};
				end
				`ADDR_LINE_STATUS: begin
					rdata_next = {2'h0, lineAbsent_reg, linePol_reg, linePeriod_reg};
				end
				`ADDR_FRAME_STATUS: begin
					rdata_next = {2'h0, frameAbsent_reg, framePol_reg, framePeriod_reg};
				end
				default: begin
					rdata_next = 16'h0000;
				end
			endcase
		end
		lineMode = line_mode_t'(ctrl_reg[`CTRL_MODE_LSB +: 2]); // see (R19)
		pulseWidth = ctrl_reg[`CTRL_WIDTH_LSB +: 5];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= `CTRL_RESET;
			freeRun_reg <= `FREE_RUN_RESET;
			rdata_reg <= 16'h0000;
		end else begin
			ctrl_reg <= ctrl_next;
			freeRun_reg <= freeRun_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;

	// Line period, presence and polarity detection.
	period_t lineCount_reg, lineCount_next;
	logic [1:0] lineEdges_reg, lineEdges_next;
	period_t lineCapture_reg, lineCapture_next;
	logic lineUpdate_reg, lineUpdate_next;
	logic lineStatic_reg, lineStatic_next;
	logic [3:0] riseFilt_reg, riseFilt_next;
	logic [1:0] fallFilt_reg, fallFilt_next;
	period_t linePhase_reg, linePhase_next;
	logic [5:0] polFilt_reg, polFilt_next;
	period_t linePeriod_next;
	logic lineAbsent_next, linePol_next;
	logic lineEvent, linePolEvent;
	logic lineAtTop, fourthEdge;
	logic [1:0] lineCmp;
	logic [5:0] polLimit;

	always_comb begin
		lineAtTop = lineCount_reg == `UPPER_THRESHOLD;
		fourthEdge = lineRise && lineEdges_reg == 2'h3;
		lineCmp = periodCompare(lineCount_reg, linePeriod_reg);
		lineCount_next = lineCount_reg + 12'h001;
		lineEdges_next = lineEdges_reg;
		lineCapture_next = lineCapture_reg;
		lineUpdate_next = 1'b0;
		lineStatic_next = lineStatic_reg;
		riseFilt_next = riseFilt_reg;
		fallFilt_next = fallFilt_reg;
		lineEvent = 1'b0;
		if (lineRise) begin
			lineEdges_next = lineEdges_reg + 2'h1;
		end
		if (fourthEdge || lineAtTop) begin
			lineCount_next = 12'h000; // see (R1) (R3)
		end
		if (lineAtTop) begin
			lineEdges_next = 2'h0;
			if (!lineStatic_reg) begin
				lineStatic_next = 1'b1; // see (R5)
				lineCapture_next = `UPPER_THRESHOLD;
				lineUpdate_next = 1'b1;
				lineEvent = 1'b1; // see (R7)
				riseFilt_next = 4'h0;
				fallFilt_next = 2'h0;
			end
		end else if (fourthEdge) begin
			lineStatic_next = 1'b0;
			if (lineCmp[1]) begin
				fallFilt_next = 2'h0;
				if ((riseFilt_reg + 4'h1) == `RISE_LIMIT) begin
					riseFilt_next = 4'h0; // see (R4)
					lineCapture_next = lineCount_reg;
					lineUpdate_next = 1'b1;
					lineEvent = 1'b1;
				end else begin
					riseFilt_next = riseFilt_reg + 4'h1;
				end
			end else if (lineCmp[0]) begin
				riseFilt_next = 4'h0;
				if ((fallFilt_reg + 2'h1) == `FALL_LIMIT) begin
					fallFilt_next = 2'h0; // see (R6)
					lineCapture_next = lineCount_reg;
					lineUpdate_next = 1'b1;
					lineEvent = 1'b1;
				end else begin
					fallFilt_next = fallFilt_reg + 2'h1;
				end
			end else begin
				// A stable period drains both filters.
				if (riseFilt_reg != 4'h0) begin
					riseFilt_next = riseFilt_reg - 4'h1; // see (R13)
				end
				if (fallFilt_reg != 2'h0) begin
					fallFilt_next = fallFilt_reg - 2'h1; // see (R13)
				end
			end
		end
		linePeriod_next = linePeriod_reg;
		lineAbsent_next = lineAbsent_reg;
		if (lineUpdate_reg) begin
			linePeriod_next = lineCapture_reg; // see (R2) (R13)
			lineAbsent_next = nextAbsent(lineCapture_reg, lineAbsent_reg); // see (R8) (R9)
		end
		// Polarity: level a quarter line after the rising edge, high means negative.
		linePhase_next = linePhase_reg;
		if (lineRise) begin
			linePhase_next = 12'h000;
		end else if (linePhase_reg != 12'hFFF) begin
			linePhase_next = linePhase_reg + 12'h001;
		end
		polLimit = linePol_reg ? `POL_NEG_TO_POS : `POL_POS_TO_NEG; // see (R10) (R11)
		polFilt_next = polFilt_reg;
		linePol_next = linePol_reg;
		linePolEvent = 1'b0;
		if (!lineRise && linePhase_reg == {4'h0, linePeriod_reg[11:4]}) begin
			if (lineLevel_reg != linePol_reg) begin
				if ((polFilt_reg + 6'h01) == polLimit) begin
					polFilt_next = 6'h00;
					linePol_next = lineLevel_reg; // see (R12)
					linePolEvent = 1'b1;
				end else begin
					polFilt_next = polFilt_reg + 6'h01;
				end
			end else begin
				polFilt_next = 6'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lineCount_reg <= 12'h000;
			lineEdges_reg <= 2'h0;
			lineCapture_reg <= 12'h000;
			lineUpdate_reg <= 1'b0;
			lineStatic_reg <= 1'b0;
			riseFilt_reg <= 4'h0;
			fallFilt_reg <= 2'h0;
			linePhase_reg <= 12'h000;
			polFilt_reg <= 6'h00;
			linePeriod_reg <= 12'h000;
			lineAbsent_reg <= 1'b0;
			linePol_reg <= 1'b0;
		end else begin
			lineCount_reg <= lineCount_next;
			lineEdges_reg <= lineEdges_next;
			lineCapture_reg <= lineCapture_next;
			lineUpdate_reg <= lineUpdate_next;
			lineStatic_reg <= lineStatic_next;
			riseFilt_reg <= riseFilt_next;
			fallFilt_reg <= fallFilt_next;
			linePhase_reg <= linePhase_next;
			polFilt_reg <= polFilt_next;
			linePeriod_reg <= linePeriod_next;
			lineAbsent_reg <= lineAbsent_next;
			linePol_reg <= linePol_next;
		end
	end

	// Frame detection on the divided clock tick.
	logic [6:0] divide_reg, divide_next;
	logic frameTick_reg, frameTick_next;
	period_t frameCount_reg, frameCount_next;
	period_t frameCapture_reg, frameCapture_next;
	logic frameUpdate_reg, frameUpdate_next;
	logic frameStatic_reg, frameStatic_next;
	logic [2:0] persist_reg, persist_next;
	logic [2:0] framePolFilt_reg, framePolFilt_next;
	period_t framePeriod_next;
	logic frameAbsent_next, framePol_next;
	logic frameEvent, framePolEvent;
	logic frameAtTop;
	logic [1:0] frameCmp;

	always_comb begin
		divide_next = divide_reg + 7'h01;
		frameTick_next = 1'b0;
		if ((divide_reg + 7'h01) == `FRAME_DIVIDE) begin
			divide_next = 7'h00; // see (R15)
			frameTick_next = 1'b1;
		end
		frameAtTop = frameTick_reg && frameCount_reg == `UPPER_THRESHOLD;
		frameCmp = periodCompare(frameCount_reg, framePeriod_reg);
		frameCount_next = frameCount_reg;
		if (frameTick_reg) begin
			frameCount_next = frameCount_reg + 12'h001;
		end
		frameCapture_next = frameCapture_reg;
		frameUpdate_next = 1'b0;
		frameStatic_next = frameStatic_reg;
		persist_next = persist_reg;
		frameEvent = 1'b0;
		if (frameRise || frameAtTop) begin
			frameCount_next = 12'h000; // see (R14) (R15)
		end
		if (frameAtTop) begin
			if (!frameStatic_reg) begin
				frameStatic_next = 1'b1;
				frameCapture_next = `UPPER_THRESHOLD;
				frameUpdate_next = 1'b1;
				frameEvent = 1'b1;
				persist_next = 3'h0;
			end
		end else if (frameRise) begin
			frameStatic_next = 1'b0;
			if (frameCmp != 2'h0) begin
				if ((persist_reg + 3'h1) == `FRAME_PERSIST) begin
					persist_next = 3'h0; // see (R17)
					frameCapture_next = frameCount_reg;
					frameUpdate_next = 1'b1;
					frameEvent = 1'b1;
				end else begin
					persist_next = persist_reg + 3'h1;
				end
			end else begin
				persist_next = 3'h0;
			end
		end
		framePeriod_next = framePeriod_reg;
		frameAbsent_next = frameAbsent_reg;
		if (frameUpdate_reg) begin
			framePeriod_next = frameCapture_reg;
			frameAbsent_next = nextAbsent(frameCapture_reg, frameAbsent_reg); // see (R8) (R9)
		end
		framePolFilt_next = framePolFilt_reg;
		framePol_next = framePol_reg;
		framePolEvent = 1'b0;
		// No sample before a period is locked, as a zero quarter would land on the pulse itself.
		if (frameTick_reg && !frameRise && framePeriod_reg != 12'h000
			&& frameCount_reg == {2'h0, framePeriod_reg[11:2]}) begin
			if (frameLevel_reg != framePol_reg) begin
				if ((framePolFilt_reg + 3'h1) == `FRAME_PERSIST) begin
					framePolFilt_next = 3'h0;
					framePol_next = frameLevel_reg; // see (R16) (R12)
					framePolEvent = 1'b1;
				end else begin
					framePolFilt_next = framePolFilt_reg + 3'h1;
				end
			end else begin
				framePolFilt_next = 3'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			divide_reg <= 7'h00;
			frameTick_reg <= 1'b0;
			frameCount_reg <= 12'h000;
			frameCapture_reg <= 12'h000;
			frameUpdate_reg <= 1'b0;
			frameStatic_reg <= 1'b0;
			persist_reg <= 3'h0;
			framePolFilt_reg <= 3'h0;
			framePeriod_reg <= 12'h000;
			frameAbsent_reg <= 1'b0;
			framePol_reg <= 1'b0;
		end else begin
			divide_reg <= divide_next;
			frameTick_reg <= frameTick_next;
			frameCount_reg <= frameCount_next;
			frameCapture_reg <= frameCapture_next;
			frameUpdate_reg <= frameUpdate_next;
			frameStatic_reg <= frameStatic_next;
			persist_reg <= persist_next;
			framePolFilt_reg <= framePolFilt_next;
			framePeriod_reg <= framePeriod_next;
			frameAbsent_reg <= frameAbsent_next;
			framePol_reg <= framePol_next;
		end
	end

	// Line sync output generator.
	period_t subCount_reg, subCount_next;
	logic [4:0] width_reg, width_next;
	logic subPulse_reg, subPulse_next;
	logic outSync_reg, outSync_next;
	logic modeChange_reg, modeChange_next;
	period_t perLine;
	logic subZero, widthActive;

	always_comb begin
		perLine = {2'h0, linePeriod_reg[11:2]} + `SUB_MARGIN;
		subZero = subCount_reg == 12'h000;
		subCount_next = subCount_reg - 12'h001;
		subPulse_next = 1'b0;
		if (lineMode == MODE_FREE_RUN) begin
			if (subZero) begin
				subCount_next = freeRun_reg; // see (R22)
				subPulse_next = 1'b1;
			end
		end else if (lineRise) begin
			subCount_next = perLine; // see (R20)
		end else if (subZero) begin
			subCount_next = perLine; // see (R21)
			subPulse_next = lineMode != MODE_COPY_ONLY;
		end
		width_next = width_reg;
		if (subPulse_next || (lineMode == MODE_FIXED_SUB && lineRise)) begin
			width_next = pulseWidth;
		end else if (width_reg != 5'h00) begin
			width_next = width_reg - 5'h01;
		end
		widthActive = width_next != 5'h00;
		case (lineMode)
			MODE_FREE_RUN: begin
				outSync_next = widthActive; // see (R18)
			end
			MODE_COPY_SUB: begin
				outSync_next = lineLevel_next | widthActive; // see (R18)
			end
			MODE_FIXED_SUB: begin
				outSync_next = widthActive; // see (R18)
			end
			MODE_COPY_ONLY: begin
				outSync_next = lineLevel_next; // see (R18)
			end
			default: begin
				outSync_next = 1'b0;
			end
		endcase
		modeChange_next = lineEvent | linePolEvent | frameEvent | framePolEvent; // see (R23)
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			subCount_reg <= `FREE_RUN_RESET;
			width_reg <= 5'h00;
			subPulse_reg <= 1'b0;
			outSync_reg <= 1'b0;
			modeChange_reg <= 1'b0;
		end else begin
			subCount_reg <= subCount_next;
			width_reg <= width_next;
			subPulse_reg <= subPulse_next;
			outSync_reg <= outSync_next;
			modeChange_reg <= modeChange_next;
		end
	end

	assign lineSyncOutput = outSync_reg;
	assign substituteLinePulse = subPulse_reg;
	assign lineUpdateEnable = lineUpdate_reg;
	assign frameUpdateEnable = frameUpdate_reg;
	assign frameBaseClock = frameTick_reg;
	assign modeChange = modeChange_reg;

endmodule

// ### verif/sync_host_model.sv
// Purpose: Graphics host model that sends one sync stream.
// Assumes: Period and high time are counted in clk cycles.
// Notes: A stopped stream rests low, as an absent positive sync does.
`timescale 1ns/1ns
module sync_host_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [15:0] period,
	input wire logic [15:0] highTime,
	output logic syncOut
);
	logic [15:0] phaseReg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn || !run) begin
			phaseReg <= 16'h0000;
			syncOut <= 1'b0;
		end else begin
			phaseReg <= (phaseReg + 16'h0001 >= period) ? 16'h0000 : phaseReg + 16'h0001;
			syncOut <= (phaseReg < highTime);
		end
	end
endmodule

// ### verif/sync_mode_detector_sva.sv
// Purpose: Port checks for the sync mode detector.
// Assumes: Register writes are visible on the port, so ctrl is shadowed here.
// Notes: Mode dependent checks wait until a new mode has settled.
`timescale 1ns/1ns
`include "sync_mode_detector_params.svh"
module sync_mode_detector_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic lineSyncIn,
	input wire logic frameSyncIn,
	input wire sync_mode_detector_pkg::reg_addr_t addr,
	input wire sync_mode_detector_pkg::reg_data_t wdata,
	input wire logic wr,
	input wire logic rd,
	input wire sync_mode_detector_pkg::reg_data_t rdata,
	input wire logic lineSyncOutput,
	input wire logic substituteLinePulse,
	input wire logic lineUpdateEnable,
	input wire logic frameUpdateEnable,
	input wire logic frameBaseClock,
	input wire logic modeChange
);
	import sync_mode_detector_pkg::*;
	reg_data_t ctrlReg, ctrlNext;
	period_t runReg, runNext;
	logic [6:0] gapReg, gapNext;
	logic [3:0] ageReg, ageNext;
	logic tickReg, tickNext;
	logic settled, copyMode;
	always_comb begin
		ctrlNext = ctrlReg;
		runNext = runReg;
		ageNext = (ageReg == 4'hF) ? ageReg : ageReg + 4'h1;
		gapNext = frameBaseClock ? 7'h00 : ((gapReg == 7'h7F) ? gapReg : gapReg + 7'h01);
		tickNext = tickReg | frameBaseClock;
		if (wr && addr == `ADDR_CTRL) begin
			ctrlNext = {9'h000, wdata[6:0]};
			ageNext = 4'h0;
		end
		if (wr && addr == `ADDR_FREE_RUN) begin
			runNext = wdata[11:0];
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrlReg <= `CTRL_RESET;
			runReg <= `FREE_RUN_RESET;
			ageReg <= 4'hF;
			gapReg <= 7'h00;
			tickReg <= 1'b0;
		end else begin
			ctrlReg <= ctrlNext;
			runReg <= runNext;
			ageReg <= ageNext;
			gapReg <= gapNext;
			tickReg <= tickNext;
		end
	end
	assign settled = (ageReg == 4'hF);
	assign copyMode = settled && ctrlReg[1:0] == 2'h3;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence widthHeld;
		lineSyncOutput[*8] ##1 !lineSyncOutput;
	endsequence
	sequence copyHigh;
		(copyMode && lineSyncIn)[*5];
	endsequence
	sequence copyLow;
		(copyMode && !lineSyncIn)[*5];
	endsequence
	frame_tick_a: assert property (tickReg |-> frameBaseClock == (gapReg == `FRAME_DIVIDE - 7'h01))
		else $error("frame tick spacing wrong");
	free_width_a: assert property (substituteLinePulse && settled && ctrlReg[6:0] == 7'h20 |-> widthHeld)
		else $error("free run pulse width wrong");
	copy_high_a: assert property (copyHigh |-> lineSyncOutput)
		else $error("copy output not high");
	copy_low_a: assert property (copyLow |-> !lineSyncOutput)
		else $error("copy output not low");
	copy_nosub_a: assert property (copyMode |-> !substituteLinePulse)
		else $error("substitute pulse in copy mode");
	mode_pulse_a: assert property (modeChange |=> !modeChange)
		else $error("mode change longer than one cycle");
	line_enable_a: assert property (lineUpdateEnable |=> !lineUpdateEnable)
		else $error("line update enable too long");
	frame_enable_a: assert property (frameUpdateEnable |=> !frameUpdateEnable)
		else $error("frame update enable too long");
	read_idle_a: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data without read");
	ctrl_read_a: assert property (rd && addr == `ADDR_CTRL |=> rdata == ctrlReg)
		else $error("ctrl read back wrong");
	run_read_a: assert property (rd && addr == `ADDR_FREE_RUN |=> rdata == {4'h0, runReg})
		else $error("free run read back wrong");
endmodule
bind sync_mode_detector sync_mode_detector_checker chk (
	.clk(clk), .rstn(rstn), .lineSyncIn(lineSyncIn), .frameSyncIn(frameSyncIn),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.lineSyncOutput(lineSyncOutput), .substituteLinePulse(substituteLinePulse),
	.lineUpdateEnable(lineUpdateEnable), .frameUpdateEnable(frameUpdateEnable),
	.frameBaseClock(frameBaseClock), .modeChange(modeChange)
);

// ### verif/tb.sv
// Purpose: Self-checking bench for the sync mode detector.
// Assumes: Two host models drive the line and frame sync inputs.
// Notes: Delay bounds are loose where the window phase is free.
`timescale 1ns/1ns
`include "sync_mode_detector_params.svh"
module tb;
	import sync_mode_detector_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	reg_addr_t addr = 4'h0;
	reg_data_t wdata = 16'h0000;
	reg_data_t rdata;
	logic lineSyncIn, frameSyncIn, lineSyncOutput, substituteLinePulse;
	logic lineUpdateEnable, frameUpdateEnable, frameBaseClock, modeChange;
	logic lineRun = 1'b1;
	logic frameRun = 1'b0;
	logic [15:0] linePeriod = 16'h0064;
	logic [15:0] lineHigh = 16'h000A;
	int nFail = 0;
	int checksDone = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	sync_host_model lineHost (.clk(clk), .rstn(rstn), .run(lineRun), .period(linePeriod),
		.highTime(lineHigh), .syncOut(lineSyncIn));
	sync_host_model frameHost (.clk(clk), .rstn(rstn), .run(frameRun), .period(16'h1DB0),
		.highTime(16'h00C8), .syncOut(frameSyncIn));
	sync_mode_detector dut (.clk(clk), .rstn(rstn), .lineSyncIn(lineSyncIn),
		.frameSyncIn(frameSyncIn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .lineSyncOutput(lineSyncOutput), .substituteLinePulse(substituteLinePulse),
		.lineUpdateEnable(lineUpdateEnable), .frameUpdateEnable(frameUpdateEnable),
		.frameBaseClock(frameBaseClock), .modeChange(modeChange));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nFail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic inRange(input string what, input int v, input int lo, input int hi);
		check(what, 16'((v >= lo) && (v <= hi)), 16'h0001);
	endtask
	task automatic wrReg(input reg_addr_t a, input reg_data_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdReg(input reg_addr_t a, output reg_data_t d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	function automatic logic evt(input int sel);
		case (sel)
			0: return modeChange;
			1: return substituteLinePulse;
			3: return lineSyncOutput;
			default: return modeChange & frameUpdateEnable;
		endcase
	endfunction
	// Counts cycles up to the next selected event, or stops at the limit.
	task automatic waitEvent(input int sel, input int limit, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (evt(sel) !== 1'b1 && n < limit);
	endtask
	task automatic countSub(input int sel, input int len, output int k);
		k = 0;
		repeat (len) begin
			@(posedge clk);
			k += (evt(sel) === 1'b1);
		end
	endtask
	task automatic lineStep(input logic [15:0] p, input logic [15:0] h, output int n,
		output reg_data_t d);
		linePeriod <= p;
		lineHigh <= h;
		waitEvent(0, 20000, n);
		rdReg(`ADDR_LINE_STATUS, d);
	endtask
	task automatic testRegs();
		reg_data_t d;
		rdReg(`ADDR_CTRL, d);
		check("ctrl reset", d, `CTRL_RESET);
		rdReg(`ADDR_FREE_RUN, d);
		check("free run reset", d, {4'h0, `FREE_RUN_RESET});
		rdReg(`ADDR_LINE_STATUS, d);
		check("line status reset", d, 16'h0000);
		wrReg(`ADDR_CTRL, 16'hFFFF);
		rdReg(`ADDR_CTRL, d);
		check("ctrl upper bits", d, 16'h007F);
		for (int m = 3; m >= 0; m--) begin
			wrReg(`ADDR_CTRL, 16'h0020 | 16'(m));
			rdReg(`ADDR_CTRL, d);
			check("ctrl mode", d, 16'h0020 | 16'(m));
		end
		wrReg(`ADDR_LINE_STATUS, 16'h1234);
		rdReg(`ADDR_LINE_STATUS, d);
		check("status write", d, 16'h0000);
		rdReg(4'h7, d);
		check("unmapped read", d, 16'h0000);
		$display("done: registers");
	endtask
	task automatic testMeasure();
		int n;
		reg_data_t d;
		waitEvent(0, 3000, n);
		check("enable with change", 16'(lineUpdateEnable), 16'h0001);
		rdReg(`ADDR_LINE_STATUS, d);
		inRange("line period", int'(d[11:0]), 399, 401);
		check("line flags", 16'(d[13:12]), 16'h0000);
		$display("done: measure");
	endtask
	task automatic testFreeRun();
		int n;
		wrReg(`ADDR_FREE_RUN, 16'h0040);
		waitEvent(1, 2000, n);
		waitEvent(1, 2000, n);
		waitEvent(1, 2000, n);
		inRange("free run gap", n, 64, 65);
		$display("done: free run");
	endtask
	task automatic testFaster();
		int n;
		reg_data_t d;
		lineStep(16'h003C, 16'h000A, n, d);
		inRange("faster delay", n, 13 * 240, 17 * 240);
		inRange("faster period", int'(d[11:0]), 239, 241);
		$display("done: faster");
	endtask
	task automatic testSlower();
		int n;
		reg_data_t d;
		lineStep(16'h0064, 16'h000A, n, d);
		inRange("slower delay", n, 700, 2100);
		inRange("slower period", int'(d[11:0]), 399, 401);
		$display("done: slower");
	endtask
	task automatic testPolarity();
		int n;
		reg_data_t d;
		lineStep(16'h0064, 16'h005A, n, d);
		inRange("to negative delay", n, 5800, 6200);
		check("negative flag", 16'(d[12]), 16'h0001);
		lineStep(16'h0064, 16'h000A, n, d);
		inRange("to positive delay", n, 3600, 4000);
		check("positive flag", 16'(d[12]), 16'h0000);
		$display("done: polarity");
	endtask
	task automatic testMissing();
		int n;
		int k;
		reg_data_t d;
		wrReg(`ADDR_CTRL, 16'h0022);
		countSub(1, 200, k);
		countSub(3, 400, k);
		check("fixed width", 16'(k), 16'h0020);
		wrReg(`ADDR_CTRL, 16'h0021);
		countSub(1, 1000, k);
		check("no substitute", 16'(k), 16'h0000);
		lineRun <= 1'b0;
		countSub(1, 1080, k);
		inRange("substitute count", k, 9, 11);
		waitEvent(0, 4200, n);
		check("static change", 16'(modeChange), 16'h0001);
		rdReg(`ADDR_LINE_STATUS, d);
		check("static status", d, {2'h0, 2'h2, `UPPER_THRESHOLD});
		wrReg(`ADDR_CTRL, 16'h0023);
		lineRun <= 1'b1;
		waitEvent(0, 10000, n);
		rdReg(`ADDR_LINE_STATUS, d);
		check("present again", 16'(d[13]), 16'h0000);
		inRange("period again", int'(d[11:0]), 399, 401);
		$display("done: missing sync");
	endtask
	task automatic testFrame();
		int n;
		reg_data_t d;
		frameRun <= 1'b1;
		waitEvent(2, 60000, n);
		inRange("frame delay", n, 2 * 7600, 6 * 7600);
		rdReg(`ADDR_FRAME_STATUS, d);
		inRange("frame period", int'(d[11:0]), 99, 101);
		check("frame flags", 16'(d[13:12]), 16'h0000);
		$display("done: frame");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			nFail++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		testRegs();
		testMeasure();
		testFreeRun();
		testFaster();
		testSlower();
		testPolarity();
		testMissing();
		testFrame();
		conclude();
	end
endmodule
